//--- src/sfcf_flash_dev.sv
/*
  Flash device end: decodes serial instructions, keeps the status
  byte, a small flip-flop array and the self-timed write cycle.
  Assumes: link pins are asynchronous to pclk and are sampled by it;
  the serial clock half period spans at least four pclk cycles.
*/
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sfcf_params.svh"

// Contract
// RULE_01: Opcode 06h sets write enable latch
// RULE_02: Opcode 04h clears write enable latch
// RULE_03: Latch clears at reset and cycle end
// RULE_04: Host sets latch before any write
// RULE_05: Opcode 05h shifts status out, MSB first
// RULE_06: Status byte repeats until select rises
// RULE_07: Status read accepted even while busy
// RULE_08: Status write is 01h plus byte, latched
// RULE_09: Status write touches bits 7,4,3,2 only
// RULE_10: Writes need select rise on byte boundary
// RULE_11: Status write runs timed busy cycle
// RULE_12: Guard high and pin low block writes; code blocks status writes only, not program or erase
// RULE_13: Array read is 03h plus 24-bit address
// RULE_14: Addressed byte shifts out MSB first
// RULE_15: Address increments after each output byte
// RULE_16: Array read ignored while busy
// RULE_17: ABh plus three dummies returns device id
// RULE_18: 90h returns manufacturer then device id
// RULE_19: Host uses last page for low sectors
// RULE_20: Fast read adds one dummy byte
// RULE_21: Page program takes 1-256 bytes, wraps
// RULE_22: Unknown opcode ignored until select rises
module sfcf_flash_dev
#(
  parameter int         MEM_AW    = 10,    // Modelled array address bits
  parameter int         CYCLE_LEN = 64,    // Self-timed cycle, pclk cycles
  parameter logic [7:0] MFR_ID    = 8'hA5, // Arbitrary value
  parameter logic [7:0] DEV_ID    = 8'h3C  // Arbitrary value
)
(
  input  wire logic          pclk,        // System clock
  input  wire logic          presetn,     // Async reset, active low
  sfcf_link_if.dev           link,        // Serial link, device side
  output sfcf_pkg::sfcf_byte_t status_byte, // Live status byte
  output logic               busy         // Self-timed cycle running
);
  import sfcf_pkg::*;

  localparam int DEPTH = 1 << MEM_AW;
  localparam int PAGE  = 1 << `SFCF_PAGE_SHIFT;

  function automatic logic [31:0] out_start(input logic [7:0] op);
    case (op)
      `SFCF_OP_RD_STATUS:  out_start = `SFCF_BITS_CMD;
      `SFCF_OP_RD_ARRAY,
      `SFCF_OP_DEV_ID,
      `SFCF_OP_MFR_DEV_ID: out_start = `SFCF_BITS_ADDR;
      `SFCF_OP_RD_FAST:    out_start = `SFCF_BITS_FAST;
      default:             out_start = `SFCF_BITS_NEVER;
    endcase
  endfunction

  function automatic logic known_op(input logic [7:0] op);
    case (op)
      `SFCF_OP_WR_ENABLE, `SFCF_OP_WR_DISABLE, `SFCF_OP_RD_STATUS,
      `SFCF_OP_WR_STATUS, `SFCF_OP_RD_ARRAY, `SFCF_OP_RD_FAST,
      `SFCF_OP_PAGE_PROG, `SFCF_OP_SECT_ERASE, `SFCF_OP_CHIP_ERASE,
      `SFCF_OP_DEV_ID, `SFCF_OP_MFR_DEV_ID: known_op = 1'b1;
      default: known_op = 1'b0;
    endcase
  endfunction

  // Same page or sector as the latched address, within the model
  function automatic logic same_blk(input logic [MEM_AW-1:0] idx,
                                    input logic [MEM_AW-1:0] a,
                                    input int                sh);
    same_blk = (idx >> sh) == (a >> sh);
  endfunction

  logic [1:0]      cs_s_q;
  logic [1:0]      ck_s_q;
  logic [1:0]      si_s_q;
  logic [1:0]      wp_s_q;
  logic            ck_prev_q;
  logic            cs_prev_q;
  sfcf_dev_state_t st_q;
  logic [31:0]     cnt_q;
  logic [31:0]     sh_q;
  logic [7:0]      op_q;
  logic [23:0]     addr_q;
  logic [7:0]      pidx_q;
  logic [7:0]      pbuf_q [PAGE];
  logic [PAGE-1:0] pval_q;
  logic [7:0]      mem_q [DEPTH];
  logic            so_q;
  logic            oe_q;
  logic            write_enable_latch_q;
  logic            guard_q;
  logic [2:0]      bp_q;
  logic            busy_q;
  logic [7:0]      kind_q;
  logic [31:0]     cyc_q;

  // Only the second stage of each synchroniser is read
  wire        cs_n      = cs_s_q[1];
  wire        ck        = ck_s_q[1];
  wire        si        = si_s_q[1];
  wire        wp_n      = wp_s_q[1];
  wire        ck_rise   = ck & ~ck_prev_q;
  wire        ck_fall   = ~ck & ck_prev_q;
  wire        frame_end = cs_n & ~cs_prev_q;
  wire        active    = ~cs_n & (st_q != DV_IGNORE);
  wire        rise_act  = active & ck_rise;
  wire [31:0] cnt_n     = cnt_q + 32'h0000_0001;
  wire [7:0]  rx_byte   = {sh_q[6:0], si};
  wire        byte_done = rise_act & (cnt_n[2:0] == 3'h0);
  wire        is_read   = (op_q == `SFCF_OP_RD_ARRAY) |
                          (op_q == `SFCF_OP_RD_FAST);
  wire        has_addr  = is_read | (op_q == `SFCF_OP_PAGE_PROG) |
                          (op_q == `SFCF_OP_SECT_ERASE);
  wire [31:0] start     = out_start(op_q);
  wire        out_phase = active & (cnt_q >= `SFCF_BITS_CMD) &
                          (cnt_q >= start);
  wire        wr_lock   = guard_q & ~wp_n; // RULE_12
  wire        fe_ok     = frame_end & (st_q == DV_RUN) & ~busy_q &
                          (cnt_q[2:0] == 3'h0); // RULE_10
  wire        cmd1      = fe_ok & (cnt_q == `SFCF_BITS_CMD);
  wire        do_wren   = cmd1 & (op_q == `SFCF_OP_WR_ENABLE);
  wire        do_wrdi   = cmd1 & (op_q == `SFCF_OP_WR_DISABLE);
  wire        do_wrsr   = fe_ok & write_enable_latch_q & ~wr_lock &
                          (op_q == `SFCF_OP_WR_STATUS) &
                          (cnt_q == `SFCF_BITS_WRSR); // RULE_08
  wire        do_prog   = fe_ok & write_enable_latch_q &
                          (op_q == `SFCF_OP_PAGE_PROG) &
                          (cnt_q >= `SFCF_BITS_FAST);
  wire        do_sera   = fe_ok & write_enable_latch_q &
                          (op_q == `SFCF_OP_SECT_ERASE) &
                          (cnt_q == `SFCF_BITS_ADDR);
  wire        do_cera   = cmd1 & write_enable_latch_q &
                          (op_q == `SFCF_OP_CHIP_ERASE);
  wire        start_cyc = do_wrsr | do_prog | do_sera | do_cera;
  wire        cyc_done  = busy_q & (cyc_q == 32'h0000_0000);
  wire [7:0]  id_byte   = cnt_q[3] ? DEV_ID : MFR_ID; // RULE_18
  wire [7:0]  tx_byte   =
    (op_q == `SFCF_OP_RD_STATUS)  ? status_byte : // RULE_05 RULE_06
    (op_q == `SFCF_OP_DEV_ID)     ? DEV_ID :      // RULE_17
    (op_q == `SFCF_OP_MFR_DEV_ID) ? id_byte :
                                    mem_q[addr_q[MEM_AW-1:0]]; // RULE_14

  assign status_byte = {guard_q, 2'b00, bp_q, write_enable_latch_q, busy_q};
  assign busy        = busy_q;
  assign link.serial_out    = so_q;
  assign link.serial_out_oe = oe_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_s_q    <= 2'b11;
      ck_s_q    <= 2'b00;
      si_s_q    <= 2'b00;
      wp_s_q    <= 2'b11;
      ck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end
    else
    begin
      cs_s_q    <= {cs_s_q[0], link.cs_n};
      ck_s_q    <= {ck_s_q[0], link.sclk};
      si_s_q    <= {si_s_q[0], link.serial_in};
      wp_s_q    <= {wp_s_q[0], link.wp_n};
      ck_prev_q <= ck;
      cs_prev_q <= cs_n;
    end
  end

  // Frame decode; commands latched on serial clock rising edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q   <= DV_IDLE;
      cnt_q  <= 32'h0000_0000;
      sh_q   <= 32'h0000_0000;
      op_q   <= 8'h00;
      addr_q <= 24'h00_0000;
      pidx_q <= 8'h00;
    end
    else if (cs_n)
    begin
      st_q  <= DV_IDLE;
      cnt_q <= 32'h0000_0000;
    end
    else
    begin
      if (st_q == DV_IDLE)
        st_q <= DV_RUN;
      if (rise_act)
      begin
        cnt_q <= cnt_n;
        sh_q  <= {sh_q[30:0], si}; // RULE_13
      end
      if (rise_act && cnt_n == `SFCF_BITS_CMD)
      begin
        op_q <= rx_byte;
        if (!known_op(rx_byte)) // RULE_22
          st_q <= DV_IGNORE;
        else if (busy_q && rx_byte != `SFCF_OP_RD_STATUS) // RULE_07 RULE_16
          st_q <= DV_IGNORE;
      end
      if (rise_act && cnt_n == `SFCF_BITS_ADDR && has_addr)
      begin
        addr_q <= {sh_q[22:0], si}; // RULE_13
        pidx_q <= rx_byte;
      end
      if (byte_done && is_read && cnt_n > start)
        addr_q <= addr_q + 24'h00_0001; // RULE_15
      if (byte_done && op_q == `SFCF_OP_PAGE_PROG &&
          cnt_n > `SFCF_BITS_ADDR)
        pidx_q <= pidx_q + 8'h01; // RULE_21
    end
  end

  // Output changes on serial clock falling edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (!active)
      oe_q <= 1'b0; // RULE_22
    else if (ck_fall && out_phase)
    begin
      so_q <= tx_byte[~cnt_q[2:0]]; // RULE_05 RULE_14 RULE_20
      oe_q <= 1'b1;
    end
  end

  // Page buffer; wraps within the page when overrun
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pval_q <= '0;
    else if (rise_act && cnt_n == `SFCF_BITS_CMD &&
             rx_byte == `SFCF_OP_PAGE_PROG && !busy_q)
      pval_q <= '0;
    else if (byte_done && op_q == `SFCF_OP_PAGE_PROG &&
             cnt_n > `SFCF_BITS_ADDR)
    begin
      pbuf_q[pidx_q] <= rx_byte; // RULE_21
      pval_q[pidx_q] <= 1'b1;
    end
  end

  // Status bits and the self-timed cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      write_enable_latch_q <= 1'b0; // RULE_03
      guard_q <= 1'(`SFCF_SR_RESET >> `SFCF_SR_GUARD);
      bp_q    <= 3'h0;
      busy_q  <= 1'b0;
      kind_q  <= 8'h00;
      cyc_q   <= 32'h0000_0000;
    end
    else
    begin
      if (do_wren)
        write_enable_latch_q <= 1'b1; // RULE_01
      if (do_wrdi)
        write_enable_latch_q <= 1'b0; // RULE_02
      if (do_wrsr)
      begin
        guard_q <= sh_q[`SFCF_SR_GUARD]; // RULE_09
        bp_q    <= sh_q[4:2];
      end
      if (start_cyc)
      begin
        busy_q <= 1'b1; // RULE_11
        kind_q <= op_q;
        cyc_q  <= 32'(CYCLE_LEN - 1);
      end
      else if (busy_q)
        cyc_q <= cyc_q - 32'h0000_0001;
      if (cyc_done)
      begin
        busy_q <= 1'b0;
        write_enable_latch_q <= 1'b0; // RULE_03 RULE_11
      end
    end
  end

  // Array commit at the end of a program or erase cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= `SFCF_ERASED;
    end
    else if (cyc_done)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (kind_q == `SFCF_OP_CHIP_ERASE ||
            (kind_q == `SFCF_OP_SECT_ERASE &&
             same_blk(MEM_AW'(i), addr_q[MEM_AW-1:0], `SFCF_SECT_SHIFT)))
          mem_q[i] <= `SFCF_ERASED;
        else if (kind_q == `SFCF_OP_PAGE_PROG && pval_q[8'(i)] &&
                 same_blk(MEM_AW'(i), addr_q[MEM_AW-1:0],
                          `SFCF_PAGE_SHIFT))
          mem_q[i] <= mem_q[i] & pbuf_q[8'(i)];
      end
    end
  end
endmodule

//--- inc/sfcf_params.svh
/*
  Constants shared by the serial flash front end: opcodes, status bit
  positions, frame bit counts and host register map.
  Assumes: included by bare name; definitions only.
*/
`ifndef SFCF_PARAMS_SVH
`define SFCF_PARAMS_SVH

`define SFCF_OP_WR_ENABLE  8'h06
`define SFCF_OP_WR_DISABLE 8'h04
`define SFCF_OP_RD_STATUS  8'h05
`define SFCF_OP_WR_STATUS  8'h01
`define SFCF_OP_RD_ARRAY   8'h03
`define SFCF_OP_RD_FAST    8'h0B
`define SFCF_OP_PAGE_PROG  8'h02
`define SFCF_OP_SECT_ERASE 8'hD8
`define SFCF_OP_CHIP_ERASE 8'hC7
`define SFCF_OP_DEV_ID     8'hAB
`define SFCF_OP_MFR_DEV_ID 8'h90

`define SFCF_SR_BUSY       0
`define SFCF_SR_WLATCH     1
`define SFCF_SR_GUARD      7
`define SFCF_SR_WMASK      8'h9C
`define SFCF_SR_RESET      8'h00
`define SFCF_ERASED        8'hFF

`define SFCF_BITS_CMD      32'h0000_0008
`define SFCF_BITS_WRSR     32'h0000_0010
`define SFCF_BITS_ADDR     32'h0000_0020
`define SFCF_BITS_FAST     32'h0000_0028
`define SFCF_BITS_NEVER    32'hFFFF_FFFF
`define SFCF_PAGE_SHIFT    8
`define SFCF_SECT_SHIFT    12

`define SFCF_REG_CMD       12'h000
`define SFCF_REG_TXDATA    12'h004
`define SFCF_REG_RXDATA    12'h008
`define SFCF_REG_STAT      12'h00C
`define SFCF_REG_CFG       12'h010
`define SFCF_CFG_RESET     32'h0001_0010

`endif

//--- inc/sfcf_pkg.sv
/*
  Types of the serial flash front end.
  Assumes: constants come from sfcf_params.svh.
*/
package sfcf_pkg;
  typedef logic [7:0] sfcf_byte_t;
  typedef enum logic [1:0]
  {
    DV_IDLE   = 2'b00,
    DV_RUN    = 2'b01,
    DV_IGNORE = 2'b11
  } sfcf_dev_state_t;
  typedef enum logic [1:0]
  {
    HS_IDLE  = 2'b00,
    HS_SHIFT = 2'b01,
    HS_TAIL  = 2'b11,
    HS_GAP   = 2'b10
  } sfcf_host_state_t;
endpackage

//--- inc/sfcf_link_if.sv
/*
  Serial link between host and flash device.
  Assumes: the data-out line idles high when the device does not drive.
*/
`timescale 1ns/1ps
interface sfcf_link_if;
  logic cs_n;
  logic sclk;
  logic serial_in;
  logic wp_n;
  logic serial_out;
  logic serial_out_oe;
  logic serial_out_line;

  // Pulled high when undriven
  assign serial_out_line = serial_out_oe ? serial_out : 1'b1;

  modport dev
  (
    input  cs_n, sclk, serial_in, wp_n,
    output serial_out, serial_out_oe
  );
  modport host
  (
    output cs_n, sclk, serial_in, wp_n,
    input  serial_out_line
  );
endinterface

//--- src/sfcf_spi_host.sv
/*
  Host end: APB register slave that runs one serial frame per command,
  making the serial clock by dividing pclk.
  Assumes: APB master keeps the request until pready is sampled high.
*/
`timescale 1ns/1ps
`include "sfcf_params.svh"

module sfcf_spi_host
(
  input  wire logic        pclk,    // System clock
  input  wire logic        presetn, // Async reset, active low
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB access phase
  input  wire logic        pwrite,  // APB write
  input  wire logic [11:0] paddr,   // APB byte address
  input  wire logic [31:0] pwdata,  // APB write data
  output logic      [31:0] prdata,  // APB read data
  output logic             pready,  // APB ready
  output logic             pslverr, // APB error, unmapped address
  sfcf_link_if.host        link     // Serial link, host side
);
  import sfcf_pkg::*;

  logic [1:0]       so_s_q;
  logic [14:0]      cmd_q;
  logic [31:0]      tx_q;
  logic [31:0]      rx_q;
  logic [31:0]      cfg_q;
  logic [31:0]      prdata_q;
  logic             pready_q;
  logic             pslverr_q;
  sfcf_host_state_t st_q;
  logic [15:0]      tdiv_q;
  logic [7:0]       bit_q;
  logic [39:0]      txsh_q;
  logic             cs_n_q;
  logic             sclk_q;
  logic             mosi_q;

  wire        hit     = (paddr == `SFCF_REG_CMD) |
                        (paddr == `SFCF_REG_TXDATA) |
                        (paddr == `SFCF_REG_RXDATA) |
                        (paddr == `SFCF_REG_STAT) |
                        (paddr == `SFCF_REG_CFG);
  wire        acc     = psel & penable & ~pready_q;
  wire        wr_fire = psel & penable & pready_q & pwrite & hit;
  wire        idle    = (st_q == HS_IDLE);
  wire        go      = wr_fire & (paddr == `SFCF_REG_CMD) & idle;
  wire        tick    = (tdiv_q >= cfg_q[15:0] - 16'h0001);
  wire [7:0]  n_bytes = 8'h01 + {5'h00, cmd_q[10:8]} + {4'h0, cmd_q[14:11]};
  wire [7:0]  total   = {n_bytes[4:0], 3'h0};
  wire [7:0]  rx_from = {2'h0, 3'h1 + cmd_q[10:8], 3'h0};
  wire [31:0] rd_mux  =
    (paddr == `SFCF_REG_CMD)    ? {17'h0_0000, cmd_q} :
    (paddr == `SFCF_REG_TXDATA) ? tx_q :
    (paddr == `SFCF_REG_RXDATA) ? rx_q :
    (paddr == `SFCF_REG_STAT)   ? {31'h0000_0000, ~idle} :
    (paddr == `SFCF_REG_CFG)    ? cfg_q : 32'h0000_0000;

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign link.cs_n      = cs_n_q;
  assign link.sclk      = sclk_q;
  assign link.serial_in = mosi_q;
  assign link.wp_n      = cfg_q[16];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      cmd_q     <= 15'h0000;
      tx_q      <= 32'h0000_0000;
      cfg_q     <= `SFCF_CFG_RESET;
    end
    else
    begin
      pready_q <= acc;
      if (acc)
      begin
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_q <= ~hit;
      end
      // Frame settings are frozen while a frame runs
      if (go)
      begin
        cmd_q <= pwdata[14:0];
      end
      if (wr_fire && paddr == `SFCF_REG_TXDATA && idle)
        tx_q <= pwdata;
      if (wr_fire && paddr == `SFCF_REG_CFG && idle)
        cfg_q <= {15'h0000, pwdata[16:0]};
    end
  end

  // Mode 0 frame: data set while clock low, device samples on rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      so_s_q <= 2'b11;
      st_q   <= HS_IDLE;
      tdiv_q <= 16'h0000;
      bit_q  <= 8'h00;
      txsh_q <= 40'h00_0000_0000;
      rx_q   <= 32'h0000_0000;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
    end
    else
    begin
      so_s_q <= {so_s_q[0], link.serial_out_line};
      tdiv_q <= (idle || tick) ? 16'h0000 : tdiv_q + 16'h0001;
      case (st_q)
        HS_IDLE:
          if (go)
          begin
            st_q   <= HS_SHIFT;
            cs_n_q <= 1'b0;
            sclk_q <= 1'b0;
            bit_q  <= 8'h00;
            txsh_q <= {pwdata[7:0], tx_q};
            mosi_q <= pwdata[7];
          end
        HS_SHIFT:
          if (tick && !sclk_q)
          begin
            sclk_q <= 1'b1;
            if (bit_q >= rx_from)
              rx_q <= {rx_q[30:0], so_s_q[1]};
          end
          else if (tick)
          begin
            sclk_q <= 1'b0;
            bit_q  <= bit_q + 8'h01;
            txsh_q <= {txsh_q[38:0], 1'b0};
            mosi_q <= txsh_q[38];
            if (bit_q + 8'h01 == total)
              st_q <= HS_TAIL;
          end
        HS_TAIL:
          if (tick)
          begin
            cs_n_q <= 1'b1;
            st_q   <= HS_GAP;
          end
        HS_GAP:
          if (tick)
            st_q <= HS_IDLE;
        default:
          st_q <= HS_IDLE;
      endcase
    end
  end
endmodule

//--- test/sfcf_link_checker.sv
/*
  Checker for the serial link and the device status byte.
  Assumes: placed beside the link by the bench; CYCLE_LEN of at least 8.
*/
`timescale 1ns/1ps
module sfcf_link_checker
(
  input wire logic            pclk,          // System clock
  input wire logic            presetn,       // Async reset, active low
  input wire logic            cs_n,          // Link select
  input wire logic            sclk,          // Link clock
  input wire logic            serial_out,    // Device data
  input wire logic            serial_out_oe, // Device drive enable
  input wire sfcf_pkg::sfcf_byte_t status_byte, // Device status
  input wire logic            busy           // Device cycle running
);
  import sfcf_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  protect_quiet_a: assert property
    ($changed(status_byte[7:2]) |-> cs_n)
    else $error("protect bits changed inside frame");
  cycle_after_frame_a: assert property
    ($rose(busy) |-> $past(cs_n, 2))
    else $error("cycle started before select rose");
  latch_hold_a: assert property (busy |-> status_byte[1])
    else $error("latch lost during cycle");
  latch_clear_a: assert property
    ($fell(busy) |-> !status_byte[1])
    else $error("latch not cleared at cycle end");
  latch_set_a: assert property
    ($rose(status_byte[1]) |-> cs_n && !busy)
    else $error("latch set inside frame or cycle");
  cycle_start_a: assert property
    ($rose(busy) |-> cs_n && $past(status_byte[1]))
    else $error("cycle started without latch");
  cycle_len_a: assert property
    ($rose(busy) |-> busy[*8] ##[1:1000] !busy)
    else $error("cycle length wrong");
  guard_change_a: assert property
    ($changed(status_byte[7:2]) |-> ##[0:1] busy)
    else $error("protect bits changed outside cycle");
  out_on_fall_a: assert property
    ($changed(serial_out) && $past(serial_out_oe) |-> !sclk)
    else $error("data changed while clock high");
  idle_release_a: assert property (cs_n[*8] |-> !serial_out_oe)
    else $error("data driven while deselected");
  idle_clock_a: assert property (cs_n[*2] |-> !sclk)
    else $error("clock not low while deselected");
endmodule

//--- test/sfcf_tb_top.sv
/*
  Self-checking bench: host and device joined by the link, host driven
  over APB. Assumes: CYCLE_LEN long enough to poll status mid-cycle.
*/
`timescale 1ns/1ps
`include "sfcf_params.svh"
module sfcf_tb_top;
  import sfcf_pkg::*;
  localparam int         CYC = 400;
  localparam logic [7:0] MFR = 8'hA5; // Arbitrary value
  localparam logic [7:0] DEV = 8'h3C; // Arbitrary value
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic        err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rx;
  sfcf_byte_t  status_byte;
  logic [7:0]  unk [2] = '{8'h77, 8'hB9};
  int          bad_count, checks, cycles;

  sfcf_link_if link();
  sfcf_spi_host sfcf_spi_host_inst
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link.host)
  );
  sfcf_flash_dev #(.CYCLE_LEN(CYC), .MFR_ID(MFR), .DEV_ID(DEV))
  sfcf_flash_dev_inst
  (
    .pclk(pclk), .presetn(presetn), .link(link.dev),
    .status_byte(status_byte), .busy(busy)
  );
  sfcf_link_checker sfcf_link_checker_inst
  (
    .pclk(pclk), .presetn(presetn), .cs_n(link.cs_n), .sclk(link.sclk),
    .serial_out(link.serial_out), .serial_out_oe(link.serial_out_oe),
    .status_byte(status_byte), .busy(busy)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Whole run needs about 20k cycles
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp);
    checks++;
    if (rx !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, rx);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rx = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Upper RXDATA bytes may hold older frames, so mask to bytes read
  task automatic frame(input logic [7:0] op, input logic [2:0] ns,
                       input logic [31:0] tx, input logic [3:0] nr);
    apb(1'b1, `SFCF_REG_TXDATA, tx);
    apb(1'b1, `SFCF_REG_CMD, {17'h0, nr, ns, op});
    do
      apb(1'b0, `SFCF_REG_STAT, 32'h0);
    while (rx[0] !== 1'b0);
    apb(1'b0, `SFCF_REG_RXDATA, 32'h0);
    rx = rx & ~(32'hFFFF_FFFF << (8 * int'(nr)));
  endtask

  task automatic rd_st();
    frame(`SFCF_OP_RD_STATUS, 3'd0, 32'h0, 4'd1);
  endtask

  task automatic settle();
    do
      rd_st();
    while (rx[0] !== 1'b0);
  endtask

  task automatic wr_en();
    frame(`SFCF_OP_WR_ENABLE, 3'd0, 32'h0, 4'd0);
  endtask

  task automatic done(input string t);
    $display("test %s ended, mismatches %0d", t, bad_count);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SFCF_REG_CFG, 32'h0);
    chk("cfg reset", `SFCF_CFG_RESET);
    apb(1'b0, 12'h0FC, 32'h0);
    rx = {31'h0, err};
    chk("unmapped error", 32'h1);
    apb(1'b1, `SFCF_REG_CFG, 32'h0001_0008);
    rd_st();
    chk("status reset", 32'h00);
    done("reset");
    wr_en();
    rd_st();
    chk("latch set", 32'h02);
    frame(`SFCF_OP_RD_STATUS, 3'd0, 32'h0, 4'd2);
    chk("status repeat", 32'h0202);
    frame(`SFCF_OP_WR_DISABLE, 3'd0, 32'h0, 4'd0);
    rd_st();
    chk("latch clear", 32'h00);
    frame(`SFCF_OP_WR_STATUS, 3'd1, 32'h9C00_0000, 4'd0);
    rd_st();
    chk("write no latch", 32'h00);
    done("latch");
    wr_en();
    frame(`SFCF_OP_WR_STATUS, 3'd2, 32'h9C00_0000, 4'd0);
    rd_st();
    chk("write wrong length", 32'h02);
    frame(`SFCF_OP_WR_STATUS, 3'd1, 32'hFF00_0000, 4'd0);
    rd_st();
    chk("status mid cycle", 32'h9F);
    settle();
    chk("status after cycle", 32'h9C);
    done("status write");
    apb(1'b1, `SFCF_REG_CFG, 32'h0000_0008);
    wr_en();
    frame(`SFCF_OP_WR_STATUS, 3'd1, 32'h0, 4'd0);
    rd_st();
    chk("guarded refused", 32'h9E);
    apb(1'b1, `SFCF_REG_CFG, 32'h0001_0008);
    frame(`SFCF_OP_WR_STATUS, 3'd1, 32'h0, 4'd0);
    settle();
    chk("unguarded accepted", 32'h00);
    done("guard");
    wr_en();
    frame(`SFCF_OP_PAGE_PROG, 3'd4, 32'h0000_105A, 4'd0);
    settle();
    chk("program end", 32'h00);
    frame(`SFCF_OP_RD_ARRAY, 3'd3, 32'h0000_0F00, 4'd3);
    chk("array stream", 32'h00FF_5AFF);
    frame(`SFCF_OP_RD_FAST, 3'd4, 32'h0000_1000, 4'd2);
    chk("fast read", 32'h0000_5AFF);
    wr_en();
    frame(`SFCF_OP_PAGE_PROG, 3'd4, 32'h0000_2033, 4'd0);
    frame(`SFCF_OP_RD_ARRAY, 3'd3, 32'h0000_1000, 4'd1);
    chk("read while busy", 32'hFF);
    settle();
    frame(`SFCF_OP_RD_ARRAY, 3'd3, 32'h0000_2000, 4'd1);
    chk("cycle undisturbed", 32'h33);
    done("array");
    frame(`SFCF_OP_DEV_ID, 3'd3, 32'h0, 4'd2);
    chk("device id", {16'h0, DEV, DEV});
    frame(`SFCF_OP_MFR_DEV_ID, 3'd3, 32'h0, 4'd3);
    chk("maker id", {8'h0, MFR, DEV, MFR});
    foreach (unk[i])
    begin
      frame(unk[i], 3'd0, 32'h0, 4'd1);
      chk("unknown op", 32'hFF);
    end
    done("ids");
    wr_en();
    // Low sector needs its last page address
    frame(`SFCF_OP_SECT_ERASE, 3'd3, 32'h003F_0000, 4'd0);
    settle();
    chk("erase end", 32'h00);
    frame(`SFCF_OP_RD_ARRAY, 3'd3, 32'h0000_1000, 4'd1);
    chk("erased byte", 32'hFF);
    done("erase");
    wr_en();
    frame(`SFCF_OP_PAGE_PROG, 3'd4, 32'h0000_3077, 4'd0);
    settle();
    frame(`SFCF_OP_RD_ARRAY, 3'd3, 32'h0000_3000, 4'd1);
    chk("second program", 32'h77);
    wr_en();
    frame(`SFCF_OP_CHIP_ERASE, 3'd0, 32'h0, 4'd0);
    settle();
    chk("chip erase end", 32'h00);
    frame(`SFCF_OP_RD_ARRAY, 3'd3, 32'h0000_3000, 4'd1);
    chk("chip erased", 32'hFF);
    // Guard clear: a low pin must not block the write
    apb(1'b1, `SFCF_REG_CFG, 32'h0000_0008);
    wr_en();
    frame(`SFCF_OP_WR_STATUS, 3'd1, 32'h0C00_0000, 4'd0);
    settle();
    chk("pin free unguarded", 32'h0C);
    done("chip erase");
    wrap_up();
  end
endmodule
